// [rtl/ubrg_pkg.sv]
/*
 * Constants and carrier types of the serial transceiver baud rate
 * generator: register offsets, field positions, reset values, counts.
 * Assumes a 32-bit AHB-Lite bus with word-aligned registers.
 */

package ubrg_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] MODE_REG_OFF    = 8'h00;
	localparam logic [7:0] DIVISOR_REG_OFF = 8'h04;
	localparam logic [7:0] STATUS_REG_OFF  = 8'h08;

	// ----------------------------------------------------------------
	// Mode register fields
	// ----------------------------------------------------------------
	localparam int MODE_SRC_LSB   = 0;
	localparam int MODE_SYNC_BIT  = 2;
	localparam int MODE_OVER_BIT  = 3;
	localparam int MODE_CLKO_BIT  = 4;
	localparam int MODE_RTS_BIT   = 5;
	localparam int MODE_WIDTH     = 6;

	localparam logic [1:0] SRC_SYSCLK   = 2'h0;
	localparam logic [1:0] SRC_PRESCALE = 2'h1;
	localparam logic [1:0] SRC_EXTERNAL = 2'h3;

	// ----------------------------------------------------------------
	// Divisor and status fields
	// ----------------------------------------------------------------
	localparam int DIV_WIDTH       = 16;
	localparam int STAT_SCK_BIT    = 0;
	localparam int STAT_RUN_BIT    = 1;
	localparam int STAT_OVS_LSB    = 4;
	localparam int STAT_DIVCNT_LSB = 16;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [MODE_WIDTH-1:0] MODE_RESET    = 6'h00;
	localparam logic [DIV_WIDTH-1:0]  DIVISOR_RESET = 16'h0000;
	localparam logic [2:0]            PRESCALE_LAST = 3'h7;
	localparam logic [3:0]            OVS16_LAST    = 4'hF;
	localparam logic [3:0]            OVS8_LAST     = 4'h7;
	localparam logic                  MODEM_PINS_PRESENT = 1'b0;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       rts_force;
		logic       clock_out;
		logic       over;
		logic       sync;
		logic [1:0] clock_source_select;
	} ubrg_mode_s;

	typedef struct packed {
		ubrg_mode_s            mode;
		logic [DIV_WIDTH-1:0]  clock_divisor;
		logic [2:0]            sck_sync;
		logic                  sck_level;
		logic [2:0]            pre_cnt;
		logic [DIV_WIDTH-1:0]  div_cnt;
		logic [3:0]            ovs_cnt;
		logic                  sck_hi;
		logic                  sck_oe;
		logic                  sample_en;
		logic                  bit_en;
		logic                  rts_n;
		logic                  wr_pend;
		logic [7:0]            wr_addr;
		logic [31:0]           hrdata;
	} ubrg_state_s;

endpackage : ubrg_pkg

// [rtl/ubrg_top.sv]
/*
 * Baud rate generator of a serial transceiver, with its AHB-Lite
 * register slave. Gives sampling and bit enables to the receiver and
 * transmitter and drives or receives the serial clock pin.
 * Assumes one clock hclk; the serial clock pin is asynchronous to it.
 */
//
// Function
// - Source: system clock, clock/8, or pin
// - Sixteen-bit divider loaded from divisor field
// - Divisor zero stops all bit clocks except sync external
// - Divisor one bypasses the divider
// - Bit clock feeds receiver and transmitter
// - Async: divided clock samples, then /16 or /8
// - Oversampling select picks by-8 or by-16
// - Sync internal: bit clock is source/divisor
// - Sync external: pin clock used, divisor ignored
// - System clock source: exact 50:50 pin clock
// - Absent modem pins: their bits do nothing
// - Stopped clock resumes from held state
// - Configuration writes accepted while clock stopped

`timescale 1ns/1ps
`default_nettype none

module ubrg_top (
	input  wire logic        hclk,          // System clock, 40 MHz
	input  wire logic        hresetn,       // Async reset, active low
	input  wire logic        hsel,          // Slave select
	input  wire logic [31:0] haddr,         // Byte address
	input  wire logic [1:0]  htrans,        // Transfer type
	input  wire logic        hwrite,        // Write when high
	input  wire logic [2:0]  hsize,         // Transfer size
	input  wire logic [31:0] hwdata,        // Write data
	input  wire logic        hready,        // Bus ready in
	output logic             hreadyout,     // Slave ready out
	output logic             hresp,         // Response, always OKAY
	output logic [31:0]      hrdata,        // Read data
	input  wire logic        periph_clk_on, // Power manager clock gate
	input  wire logic        sck_i,         // Serial clock pin in
	output logic             sck_o,         // Serial clock pin out
	output logic             sck_oe,        // Serial clock drive enable
	output logic             sample_en,     // Receiver sampling pulse
	output logic             bit_en,        // Bit period pulse, rx and tx
	output logic             rts_n          // Request to send, low
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ubrg_pkg::ubrg_state_s s_q;
	ubrg_pkg::ubrg_state_s s_d;
	logic                  sck_half_q;
	logic                  src_en;
	logic                  div_tick;
	logic                  ext_rise;
	logic                  ext_src;
	logic                  addr_ok;
	logic [3:0]            ovs_last;
	logic [31:0]           rd_word;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;

		// Three-stage pin synchroniser; level moves when 2nd and 3rd agree
		s_d.sck_sync = {s_q.sck_sync[1:0], sck_i};
		if (s_q.sck_sync[1] == s_q.sck_sync[2]) begin
			s_d.sck_level = s_q.sck_sync[2];
		end
		ext_rise = s_d.sck_level & ~s_q.sck_level;

		ext_src = (s_q.mode.clock_source_select == ubrg_pkg::SRC_EXTERNAL)
			|| (s_q.mode.clock_source_select == 2'h2);

		// Source enable selection
		unique case (s_q.mode.clock_source_select)
			ubrg_pkg::SRC_SYSCLK: begin
				src_en = 1'b1;
			end
			ubrg_pkg::SRC_PRESCALE: begin
				src_en = (s_q.pre_cnt == ubrg_pkg::PRESCALE_LAST);
			end
			default: begin
				src_en = ext_rise;
			end
		endcase

		// Divider tick
		if (s_q.clock_divisor == '0) begin
			div_tick = 1'b0;
		end else if (s_q.clock_divisor == 16'h0001) begin
			div_tick = src_en;
		end else begin
			div_tick = src_en && (s_q.div_cnt <= 16'h0001);
		end

		ovs_last = s_q.mode.over ? ubrg_pkg::OVS8_LAST
			: ubrg_pkg::OVS16_LAST;

		s_d.sample_en = 1'b0;
		s_d.bit_en    = 1'b0;

		// Counters hold while the peripheral clock is off
		if (periph_clk_on) begin
			s_d.pre_cnt = s_q.pre_cnt + 3'h1;
			if (src_en && s_q.clock_divisor > 16'h0001) begin
				s_d.div_cnt = (s_q.div_cnt <= 16'h0001)
					? s_q.clock_divisor
					: s_q.div_cnt - 16'h0001;
				// Pin high for the last half of each period
				s_d.sck_hi = (s_d.div_cnt <= (s_q.clock_divisor >> 1));
			end else if (s_q.clock_divisor == 16'h0001) begin
				s_d.sck_hi = s_q.pre_cnt[2];
			end else if (s_q.clock_divisor == '0) begin
				s_d.sck_hi = 1'b0;
			end

			if (s_q.mode.sync) begin
				if (ext_src) begin
					s_d.bit_en = ext_rise;
				end else begin
					s_d.bit_en = div_tick;
				end
			end else begin
				// Async: divided clock samples, bit clock counts samples
				s_d.sample_en = div_tick;
				if (div_tick) begin
					if (s_q.ovs_cnt >= ovs_last) begin
						s_d.ovs_cnt = '0;
						s_d.bit_en  = 1'b1;
					end else begin
						s_d.ovs_cnt = s_q.ovs_cnt + 4'h1;
					end
				end
			end
		end

		// Pin driven only in sync mode with an internal source
		s_d.sck_oe = s_q.mode.sync && s_q.mode.clock_out && !ext_src;

		// Modem control line has no effect without the pin
		s_d.rts_n = ubrg_pkg::MODEM_PINS_PRESENT
			? ~s_q.mode.rts_force : 1'b1;

		// AHB-Lite address phase
		addr_ok = hsel && htrans[1] && hready;
		s_d.wr_pend = addr_ok && hwrite && (hsize == 3'h2);
		if (addr_ok) begin
			s_d.wr_addr = haddr[7:0];
		end
		rd_word = '0;
		unique case (haddr[7:0])
			ubrg_pkg::MODE_REG_OFF: begin
				rd_word[ubrg_pkg::MODE_WIDTH-1:0] = s_q.mode;
			end
			ubrg_pkg::DIVISOR_REG_OFF: begin
				rd_word[ubrg_pkg::DIV_WIDTH-1:0] = s_q.clock_divisor;
			end
			ubrg_pkg::STATUS_REG_OFF: begin
				rd_word[ubrg_pkg::STAT_SCK_BIT] = s_q.sck_level;
				rd_word[ubrg_pkg::STAT_RUN_BIT] = periph_clk_on;
				rd_word[ubrg_pkg::STAT_OVS_LSB +: 4] = s_q.ovs_cnt;
				rd_word[ubrg_pkg::STAT_DIVCNT_LSB +: 16] = s_q.div_cnt;
			end
			default: begin
				rd_word = '0;
			end
		endcase
		// Read data registered now so it stands through the data phase
		if (addr_ok && !hwrite) begin
			s_d.hrdata = rd_word;
		end

		// Data phase write; taken whether or not the clock is on
		if (s_q.wr_pend) begin
			unique case (s_q.wr_addr)
				ubrg_pkg::MODE_REG_OFF: begin
					s_d.mode = hwdata[ubrg_pkg::MODE_WIDTH-1:0];
					s_d.ovs_cnt = '0;
				end
				ubrg_pkg::DIVISOR_REG_OFF: begin
					s_d.clock_divisor = hwdata[ubrg_pkg::DIV_WIDTH-1:0];
					s_d.div_cnt = hwdata[ubrg_pkg::DIV_WIDTH-1:0];
					s_d.ovs_cnt = '0;
				end
				default: begin
					s_d.wr_pend = s_d.wr_pend;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '{
				mode:          ubrg_pkg::MODE_RESET,
				clock_divisor: ubrg_pkg::DIVISOR_RESET,
				sck_sync:      3'h0,
				sck_level:     1'b0,
				pre_cnt:       3'h0,
				div_cnt:       ubrg_pkg::DIVISOR_RESET,
				ovs_cnt:       4'h0,
				sck_hi:        1'b0,
				sck_oe:        1'b0,
				sample_en:     1'b0,
				bit_en:        1'b0,
				rts_n:         1'b1,
				wr_pend:       1'b0,
				wr_addr:       8'h00,
				hrdata:        32'h00000000
			};
		end else begin
			s_q <= s_d;
		end
	end

	// Half-cycle copy lets an odd divisor on the system clock source reach exact 50:50 on the pin
	always_ff @(negedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sck_half_q <= 1'b0;
		end else begin
			sck_half_q <= s_q.sck_hi;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Only this output mixes two flops; unavoidable for odd-divisor duty
	assign sck_o = s_q.sck_hi
		| (sck_half_q && s_q.clock_divisor[0]
		&& s_q.clock_divisor != 16'h0001
		&& s_q.mode.clock_source_select == ubrg_pkg::SRC_SYSCLK);
	assign sck_oe    = s_q.sck_oe;
	assign sample_en = s_q.sample_en;
	assign bit_en    = s_q.bit_en;
	assign rts_n     = s_q.rts_n;
	assign hrdata    = s_q.hrdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

endmodule : ubrg_top // ubrg_top

`default_nettype wire

// [verif/ubrg_sck_src.sv]
/*
 * Remote clock source for the serial clock pin (external source).
 * Assumes the bench resolves the pin from this and the design.
 */
`timescale 1ns/1ps
`default_nettype none

module ubrg_sck_src #(
	parameter int HALF_NS = 125
) (
	input  wire logic en,  // Run
	output logic      sck  // Pin drive
);
	// Stands low between runs; each phase far above one hclk
	initial sck = 1'b0;
	always #(HALF_NS) sck = en ? ~sck : 1'b0;
endmodule // ubrg_sck_src

`default_nettype wire

// [verif/ubrg_chk.sv]
/*
 * Checker of ubrg_top: pulse spacing, zero divisor, gating, readback.
 * Assumes a bind to ubrg_top and single register transfers.
 */
`timescale 1ns/1ps
`default_nettype none

module ubrg_chk (
	input wire logic        hclk,          // Clock
	input wire logic        hresetn,       // Reset
	input wire logic        hsel,          // Select
	input wire logic [31:0] haddr,         // Address
	input wire logic [1:0]  htrans,        // Transfer
	input wire logic        hwrite,        // Write
	input wire logic [2:0]  hsize,         // Size
	input wire logic [31:0] hwdata,        // Data
	input wire logic        hready,        // Ready
	input wire logic [31:0] hrdata,        // Read data
	input wire logic        periph_clk_on, // Gate
	input wire logic        sck_i,         // Pin
	input wire logic        sample_en,     // Sample
	input wire logic        bit_en,        // Bit
	input wire logic        rts_n          // Modem
);
	ubrg_pkg::ubrg_mode_s m_q;
	logic [15:0]          div_q;
	logic [7:0]           a_q;
	logic                 wr_q, rd_q, tk, ext, fresh;
	logic [23:0]          sg_q, bg_q, s_exp, b_exp;
	logic [1:0]           ss_q, bs_q;

	// Spacing judged from the third pulse after a change only
	always_comb begin
		tk = hsel && htrans[1] && hready;
		ext = m_q.clock_source_select[1];
		fresh = wr_q || !periph_clk_on;
		s_exp = (m_q.clock_source_select == 2'h1) ? {5'h00, div_q, 3'h0}
			: {8'h00, div_q};
		b_exp = m_q.sync ? s_exp : m_q.over ? {s_exp[20:0], 3'h0}
			: {s_exp[19:0], 4'h0};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{m_q, div_q, a_q, wr_q, rd_q, sg_q, bg_q, ss_q, bs_q} <= '0;
		end else begin
			wr_q <= tk && hwrite && hsize == 3'h2;
			rd_q <= tk && !hwrite;
			if (tk) a_q <= haddr[7:0];
			if (wr_q && a_q == ubrg_pkg::MODE_REG_OFF) m_q <= hwdata[5:0];
			if (wr_q && a_q == ubrg_pkg::DIVISOR_REG_OFF) div_q <= hwdata[15:0];
			sg_q <= sample_en ? 24'h0 : sg_q + 24'h1;
			bg_q <= bit_en ? 24'h0 : bg_q + 24'h1;
			ss_q <= fresh ? 2'h0 : ss_q + {1'b0, sample_en && ss_q != 2'h2};
			bs_q <= fresh ? 2'h0 : bs_q + {1'b0, bit_en && bs_q != 2'h2};
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_sgap;
		sample_en && ss_q == 2'h2 && !ext && !m_q.sync && div_q != 16'h0
			|-> sg_q == s_exp - 24'h1;
	endproperty
	a_sgap: assert property (p_sgap) else $error("sample spacing");
	property p_bgap;
		bit_en && bs_q == 2'h2 && !ext && div_q != 16'h0
			|-> bg_q == b_exp - 24'h1;
	endproperty
	a_bgap: assert property (p_bgap) else $error("bit spacing");
	property p_zero;
		(div_q == 16'h0 && !(m_q.sync && ext)) [*4] |-> !sample_en && !bit_en;
	endproperty
	a_zero: assert property (p_zero) else $error("pulse at zero");
	property p_coin;
		bit_en && !m_q.sync && m_q == $past(m_q, 2) |-> sample_en;
	endproperty
	a_coin: assert property (p_coin) else $error("bit without sample");
	property p_ext;
		$rose(sck_i) && m_q.sync && ext && periph_clk_on |-> ##[2:7] bit_en;
	endproperty
	a_ext: assert property (p_ext) else $error("pin edge lost");
	property p_stop;
		!periph_clk_on && !$past(periph_clk_on) |-> !sample_en && !bit_en;
	endproperty
	a_stop: assert property (p_stop) else $error("pulse while gated");
	property p_rd;
		rd_q && a_q == ubrg_pkg::MODE_REG_OFF |-> hrdata == {26'h0, $past(m_q)};
	endproperty
	a_rd: assert property (p_rd) else $error("mode readback");
	property p_rts;
		rts_n;
	endproperty
	a_rts: assert property (p_rts) else $error("modem line moved");

	c_bgap: cover property (bit_en && bs_q == 2'h2 && div_q != 16'h0);
	c_ext: cover property (bit_en && m_q.sync && ext);
	c_stop: cover property (!periph_clk_on ##1 periph_clk_on);
endmodule // ubrg_chk

bind ubrg_top ubrg_chk u_ubrg_chk (.*);

`default_nettype wire

// [verif/test_usart_baud_rate_generator.sv]
/*
 * Testbench of ubrg_top: registers, pulse spacing, gating, pin clock.
 * Assumes ubrg_chk bound to the design and the pin model beside it.
 */
`timescale 1ns/1ps
`default_nettype none

module test_usart_baud_rate_generator;
	logic        hclk, hresetn, hsel, hwrite, periph_clk_on, ext_en;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire logic   hready, hresp, sck_o, sck_oe, sample_en, bit_en, rts_n;
	wire logic   ext_sck;
	wire logic   sck_i = sck_oe ? sck_o : ext_sck;
	int          n_fail = 0, checks = 0, cyc = 0, g;
	realtime     t0, t1, t2;
	// Rows: mode, divisor, sample and bit spacing in cycles (0: none)
	logic [31:0] md [7] = '{32'h8, 32'h0, 32'h8, 32'h9, 32'h4, 32'h5, 32'h7};
	logic [15:0] dv [7] = '{16'h2, 16'h3, 16'h1, 16'h1, 16'h5, 16'h2, 16'h0};
	int          sx [7] = '{2, 3, 1, 8, 0, 0, 0};
	int          bx [7] = '{16, 48, 8, 64, 5, 16, 10};

	ubrg_top u_ubrg_top (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hresp(hresp),
		.hrdata(hrdata), .periph_clk_on(periph_clk_on), .sck_i(sck_i),
		.sck_o(sck_o), .sck_oe(sck_oe), .sample_en(sample_en),
		.bit_en(bit_en), .rts_n(rts_n)
	);
	ubrg_sck_src #(.HALF_NS(125)) u_ubrg_sck_src (.en(ext_en), .sck(ext_sck));

	initial hclk = 1'b0;
	always #12.5 hclk = ~hclk;

	task automatic stop_test();
		if (n_fail == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 10000) begin
			n_fail++;
			stop_test();
		end
	end

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask

	// Cycles between two pulses of the chosen output
	task automatic gap(input logic b, output int n);
		do @(posedge hclk); while ((b ? bit_en : sample_en) !== 1'b1);
		n = 0;
		do begin @(posedge hclk); n++; end while ((b ? bit_en : sample_en) !== 1'b1);
	endtask

	initial begin
		{hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
		hresetn = 1'b0;
		periph_clk_on = 1'b1;
		ext_en = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 8'h00, 0); chk("mode_rst", 32'h0, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
		// No interrupt output; the bench senses no edge of one
		bus(1'b0, 8'h04, 0); chk("div_rst", 32'h0, rd);
		bus(1'b0, 8'h0C, 0); chk("unmapped", 32'h0, rd);
		bus(1'b0, 8'h08, 0); chk("gate_flag", 32'h2, rd & 32'h2);
		g = 0;
		repeat (200) begin @(posedge hclk); if (sample_en !== 1'b0 || bit_en !== 1'b0) g++; end
		chk("zero_div", 0, g);
		for (int i = 0; i < 7; i++) begin
			ext_en <= (i == 6);
			bus(1'b1, 8'h00, md[i]);
			bus(1'b1, 8'h04, {16'h0, dv[i]});
			if (sx[i] != 0) begin gap(1'b0, g); gap(1'b0, g); chk("s_gap", sx[i], g); end
			gap(1'b1, g); gap(1'b1, g); chk("b_gap", bx[i], g);
		end
		ext_en <= 1'b0;
		repeat (12) @(posedge hclk);
		bus(1'b1, 8'h00, 32'h8);
		bus(1'b1, 8'h04, 32'h14);
		gap(1'b0, g); gap(1'b0, g);
		repeat (5) @(posedge hclk);
		periph_clk_on <= 1'b0;
		bus(1'b1, 8'h00, 32'h28);
		bus(1'b0, 8'h00, 0); chk("gated_wr", 32'h28, rd);
		repeat (26) @(posedge hclk);
		periph_clk_on <= 1'b1;
		g = 35;
		do begin @(posedge hclk); g++; end while (sample_en !== 1'b1);
		chk("resume", 50, g);
		bus(1'b1, 8'h00, 32'h14);
		bus(1'b1, 8'h04, 32'h3);
		@(posedge sck_o);
		@(posedge sck_o) t0 = $realtime;
		@(negedge sck_o) t1 = $realtime;
		@(posedge sck_o) t2 = $realtime;
		chk("sck_oe", 32'h1, {31'h0, sck_oe});
		chk("high", 375, 32'(int'((t1 - t0) * 10.0)));
		chk("low", 375, 32'(int'((t2 - t1) * 10.0)));
		stop_test();
	end
endmodule // test_usart_baud_rate_generator

`default_nettype wire
